// ---- hw/rxs_sequencer.sv ----
// Purpose: next-state choice after receive, receive timeout and frame capture
// Assumes: receive-path events are one-cycle pulses from logic on clk
// Notes: start and stop arrive as control register commands
//
// Functional notes
// - code 001: payload complete goes to captured
// - code 010: payload complete takes low-energy choice
// - code 011: check good goes to captured
// - codes 100-110 halt on strength, sync, preamble
// - timeout code 00 relaunches receiver, back receive
// - timeout codes 01-11: transmit, low-energy, halt
// - code 011: payload complete applies timeout choice
// - any of three waits counts as timeout
// - captured code 000 halts, 010 low-energy choice
// - captured code 001 transmits once queue drained
// - code 011 via synth if retuned, 100 direct
// - low-energy choice: halted or idle by bit
// - idle: standby when bit 0, sleep when 1
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
module rxs_sequencer import rxs_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon slave
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // receive-path events
  input wire rxs_events_type rxEvents,
  input wire logic freqChanged,
  // sequencer state and chip mode
  output rxs_state_type seqState,
  output logic receiverRelaunch,
  output logic synthOnlyMode,
  output logic initialMode,
  output logic idleStandby,
  output logic idleSleep,
  // interrupt
  output logic irq
);

  initial begin
    if (ADDR_W < 8) begin
      $error("rxs_sequencer needs at least 8 address bits");
    end
  end

  // -----------------------------------------------------------------
  // registers and interrupt
  // -----------------------------------------------------------------
  rxs_trans_type trans;
  logic lowEnergyChoice;
  logic idleDepthBit;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] eventPulse;
  logic cmdStart;
  logic cmdStop;
  logic statusClear;
  logic codeWarn;

  rxs_regs #(
    .ADDR_W(ADDR_W)
  ) u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .avsAddress(avsAddress),
    .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest),
    .seqState(seqState),
    .irqStatus(irqStatus),
    .trans(trans),
    .lowEnergyChoice(lowEnergyChoice),
    .idleDepthBit(idleDepthBit),
    .irqMask(irqMask),
    .cmdStart(cmdStart),
    .cmdStop(cmdStop),
    .statusClear(statusClear),
    .codeWarn(codeWarn)
  );

  rxs_irq u_irq (
    .clk(clk),
    .sys_rst(sys_rst),
    .eventPulse(eventPulse),
    .irqMask(irqMask),
    .statusClear(statusClear),
    .irqStatus(irqStatus),
    .irq(irq)
  );

  // -----------------------------------------------------------------
  // transition decoding
  // -----------------------------------------------------------------
  // low-energy target
  function automatic rxs_state_type lowEnergyTarget(input logic sel);
    lowEnergyTarget = sel ? ST_IDLE : ST_HALTED;
  endfunction

  function automatic rxs_state_type timeoutTarget(input logic [1:0] code, input logic sel);
    case (code)
      TMO_RELAUNCH: timeoutTarget = ST_RESTART;
      TMO_TRANSMIT: timeoutTarget = ST_TRANSMIT;
      TMO_LOW_ENERGY: timeoutTarget = lowEnergyTarget(sel);
      default: timeoutTarget = ST_HALTED;
    endcase
  endfunction

  rxs_state_type state_r, state_nxt;
  logic relaunch_r, relaunch_nxt;
  logic synth_r, synth_nxt;
  logic initial_r, initial_nxt;
  logic standby_r, standby_nxt;
  logic sleep_r, sleep_nxt;
  logic rxExpiry;
  logic primaryHit;
  logic timeoutTaken;

  always_comb begin
    // any wait expiry is a timeout
    rxExpiry = rxEvents.strengthWaitExpiry | rxEvents.preambleWaitExpiry | rxEvents.syncWaitExpiry;
    state_nxt = state_r;
    primaryHit = 1'b0;
    timeoutTaken = 1'b0;
    case (state_r)
      ST_HALTED, ST_IDLE: begin
        if (cmdStart) begin
          state_nxt = ST_RECEIVE;
        end
      end
      ST_RECEIVE: begin
        case (trans.afterRxSelect)
          RX_TO_CAPT_PAYLOAD: begin
            if (rxEvents.payloadCompleteEvent) begin
              primaryHit = 1'b1;
              state_nxt = ST_CAPTURED;
            end
          end
          RX_TO_LOWE_PAYLOAD: begin
            if (rxEvents.payloadCompleteEvent) begin
              primaryHit = 1'b1;
              state_nxt = lowEnergyTarget(lowEnergyChoice);
            end
          end
          RX_TO_CAPT_CHECK: begin
            if (rxEvents.checkGoodEvent) begin
              primaryHit = 1'b1;
              state_nxt = ST_CAPTURED;
            end else if (rxEvents.payloadCompleteEvent) begin
              primaryHit = 1'b1;
              timeoutTaken = 1'b1;
              state_nxt = timeoutTarget(trans.afterRxTimeoutSelect, lowEnergyChoice);
            end
          end
          RX_HALT_STRENGTH: begin
            if (rxEvents.signalStrengthEvent) begin
              primaryHit = 1'b1;
              state_nxt = ST_HALTED;
            end
          end
          RX_HALT_SYNC: begin
            if (rxEvents.syncMatchEvent) begin
              primaryHit = 1'b1;
              state_nxt = ST_HALTED;
            end
          end
          // code 110 is the preamble halt
          RX_HALT_PREAMBLE: begin
            if (rxEvents.preambleSeenEvent) begin
              primaryHit = 1'b1;
              state_nxt = ST_HALTED;
            end
          end
          default: begin
            primaryHit = 1'b0;
          end
        endcase
        if (!primaryHit && rxExpiry) begin
          timeoutTaken = 1'b1;
          state_nxt = timeoutTarget(trans.afterRxTimeoutSelect, lowEnergyChoice);
        end
      end
      ST_RESTART: begin
        state_nxt = ST_RECEIVE;
      end
      ST_CAPTURED: begin
        case (trans.afterFrameCapturedSelect)
          CAP_HALT: state_nxt = ST_HALTED;
          CAP_LOW_ENERGY: state_nxt = lowEnergyTarget(lowEnergyChoice);
          CAP_TX_DRAINED: begin
            if (rxEvents.queueDrainedEvent) begin
              state_nxt = ST_TRANSMIT;
            end
          end
          CAP_RX_SYNTH: state_nxt = freqChanged ? ST_SYNTH : ST_RECEIVE;
          CAP_RX_DIRECT: state_nxt = ST_RECEIVE;
          default: state_nxt = ST_CAPTURED;
        endcase
      end
      ST_SYNTH: begin
        state_nxt = ST_RECEIVE;
      end
      ST_TRANSMIT: begin
        state_nxt = ST_TRANSMIT;
      end
      default: begin
        state_nxt = ST_HALTED;
      end
    endcase
    if (cmdStop) begin
      state_nxt = ST_HALTED;
      timeoutTaken = 1'b0;
    end
    // chip mode follows the state being entered
    relaunch_nxt = (state_nxt == ST_RESTART);
    synth_nxt = (state_nxt == ST_SYNTH);
    initial_nxt = (state_nxt == ST_HALTED);
    standby_nxt = (state_nxt == ST_IDLE) & ~idleDepthBit;
    sleep_nxt = (state_nxt == ST_IDLE) & idleDepthBit;
    eventPulse = '0;
    eventPulse[IRQ_HALTED] = (state_nxt == ST_HALTED) & (state_r != ST_HALTED);
    eventPulse[IRQ_CAPTURED] = (state_nxt == ST_CAPTURED) & (state_r != ST_CAPTURED);
    eventPulse[IRQ_TIMEOUT] = timeoutTaken;
    eventPulse[IRQ_RELAUNCH] = relaunch_nxt;
    eventPulse[IRQ_CODE] = codeWarn;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_HALTED;
      relaunch_r <= 1'b0;
      synth_r <= 1'b0;
      initial_r <= 1'b1;
      standby_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      relaunch_r <= relaunch_nxt;
      synth_r <= synth_nxt;
      initial_r <= initial_nxt;
      standby_r <= standby_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  assign seqState = state_r;
  assign receiverRelaunch = relaunch_r;
  assign synthOnlyMode = synth_r;
  assign initialMode = initial_r;
  assign idleStandby = standby_r;
  assign idleSleep = sleep_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // payload to captured
  a_rx_payload_capt: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h1 && rxEvents.payloadCompleteEvent && !cmdStop
    |=> state_r == ST_CAPTURED)
    else $error("payload complete did not reach captured");

  a_rx_payload_lowe: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h2 && rxEvents.payloadCompleteEvent && !cmdStop
    |=> state_r == ($past(lowEnergyChoice) ? ST_IDLE : ST_HALTED))
    else $error("payload complete missed low-energy choice");

  a_rx_check_capt: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h3 && rxEvents.checkGoodEvent && !cmdStop
    |=> state_r == ST_CAPTURED && initial_r == 1'b0)
    else $error("check good did not reach captured");

  a_rx_sync_halt: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h5 && rxEvents.syncMatchEvent
    |=> state_r == ST_HALTED && initialMode)
    else $error("sync match did not halt");

  a_tmo_relaunch: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h1 && trans.afterRxTimeoutSelect == 2'h0
    && rxExpiry && !rxEvents.payloadCompleteEvent && !cmdStop
    |=> receiverRelaunch ##1 (!receiverRelaunch && (state_r == ST_RECEIVE || state_r == ST_HALTED)))
    else $error("timeout did not relaunch the receiver");

  a_tmo_transmit: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h4 && trans.afterRxTimeoutSelect == 2'h1
    && rxEvents.strengthWaitExpiry && !rxEvents.signalStrengthEvent && !cmdStop
    |=> state_r == ST_TRANSMIT)
    else $error("timeout did not reach transmit");

  a_check_payload: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h3 && trans.afterRxTimeoutSelect == 2'h3
    && rxEvents.payloadCompleteEvent && !rxEvents.checkGoodEvent
    |=> state_r == ST_HALTED)
    else $error("payload complete ignored timeout choice");

  a_sync_wait_tmo: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_RECEIVE && trans.afterRxSelect == 3'h6 && trans.afterRxTimeoutSelect == 2'h3
    && rxEvents.syncWaitExpiry && !rxEvents.preambleSeenEvent && !cmdStop
    |=> state_r == ST_HALTED && irqStatus[IRQ_TIMEOUT])
    else $error("sync wait expiry not taken as timeout");

  a_capt_halt: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_CAPTURED && trans.afterFrameCapturedSelect == 3'h0
    |=> state_r == ST_HALTED)
    else $error("captured did not halt");

  a_capt_drained: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_CAPTURED && trans.afterFrameCapturedSelect == 3'h1 && !cmdStop
    |=> state_r == ($past(rxEvents.queueDrainedEvent) ? ST_TRANSMIT : ST_CAPTURED))
    else $error("captured left too early or too late");

  a_capt_synth: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_CAPTURED && trans.afterFrameCapturedSelect == 3'h3 && freqChanged && !cmdStop
    |=> synthOnlyMode && state_r == ST_SYNTH ##1 (state_r == ST_RECEIVE || state_r == ST_HALTED))
    else $error("retune did not pass synth mode");

  a_capt_lowe: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_CAPTURED && trans.afterFrameCapturedSelect == 3'h2 && !cmdStop
    |=> state_r == ($past(lowEnergyChoice) ? ST_IDLE : ST_HALTED))
    else $error("low-energy choice ignored");

  a_idle_depth: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_IDLE |-> idleSleep == $past(idleDepthBit) && idleStandby == !$past(idleDepthBit))
    else $error("idle mode does not follow depth bit");

  a_code_flag: assert property (@(posedge clk) disable iff (sys_rst)
    codeWarn |=> irqStatus[IRQ_CODE])
    else $error("code conflict not flagged");

endmodule // rxs_sequencer

// ---- hw/rxs_pkg.sv ----
// Purpose: shared constants and types of the receive-side sequencer transitions
// Assumes: registers in the low byte of a 32-bit Avalon-MM word
// Notes: byte address of a register is four times its index
package rxs_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_TRANS = 8'h37;
  localparam logic [7:0] IDX_CTRL = 8'h3c;
  localparam logic [7:0] IDX_STATUS = 8'h3d;
  localparam logic [7:0] IDX_IRQ = 8'h3e;
  localparam logic [7:0] IDX_MASK = 8'h3f;
  localparam int unsigned WORD_SHIFT = 2;
  localparam logic [7:0] RST_TRANS = 8'h00;
  localparam logic RST_LOW_ENERGY = 1'b0;
  localparam logic RST_IDLE_DEPTH = 1'b0;

  // control register bits
  localparam int unsigned CTRL_LOW_ENERGY = 0;
  localparam int unsigned CTRL_IDLE_DEPTH = 1;
  localparam int unsigned CTRL_START = 2;
  localparam int unsigned CTRL_STOP = 3;

  // -----------------------------------------------------------------
  // transition codes
  // -----------------------------------------------------------------
  localparam logic [2:0] RX_TO_CAPT_PAYLOAD = 3'h1;
  localparam logic [2:0] RX_TO_LOWE_PAYLOAD = 3'h2;
  localparam logic [2:0] RX_TO_CAPT_CHECK = 3'h3;
  localparam logic [2:0] RX_HALT_STRENGTH = 3'h4;
  localparam logic [2:0] RX_HALT_SYNC = 3'h5;
  localparam logic [2:0] RX_HALT_PREAMBLE = 3'h6;
  localparam logic [2:0] RX_UNUSED_LO = 3'h0;
  localparam logic [2:0] RX_UNUSED_HI = 3'h7;
  localparam logic [1:0] TMO_RELAUNCH = 2'h0;
  localparam logic [1:0] TMO_TRANSMIT = 2'h1;
  localparam logic [1:0] TMO_LOW_ENERGY = 2'h2;
  localparam logic [1:0] TMO_HALT = 2'h3;
  localparam logic [2:0] CAP_HALT = 3'h0;
  localparam logic [2:0] CAP_TX_DRAINED = 3'h1;
  localparam logic [2:0] CAP_LOW_ENERGY = 3'h2;
  localparam logic [2:0] CAP_RX_SYNTH = 3'h3;
  localparam logic [2:0] CAP_RX_DIRECT = 3'h4;

  // -----------------------------------------------------------------
  // interrupt status bits
  // -----------------------------------------------------------------
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_HALTED = 0;
  localparam int unsigned IRQ_CAPTURED = 1;
  localparam int unsigned IRQ_TIMEOUT = 2;
  localparam int unsigned IRQ_RELAUNCH = 3;
  localparam int unsigned IRQ_CODE = 4;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HALTED = 3'h0,
    ST_RECEIVE = 3'h1,
    ST_CAPTURED = 3'h3,
    ST_SYNTH = 3'h2,
    ST_IDLE = 3'h6,
    ST_TRANSMIT = 3'h7,
    ST_RESTART = 3'h5
  } rxs_state_type;

  // same layout as the transitions register, bits 7-5, 4-3, 2-0
  typedef struct packed {
    logic [2:0] afterRxSelect;
    logic [1:0] afterRxTimeoutSelect;
    logic [2:0] afterFrameCapturedSelect;
  } rxs_trans_type;

  typedef struct packed {
    logic preambleWaitExpiry;
    logic syncWaitExpiry;
    logic strengthWaitExpiry;
    logic queueDrainedEvent;
    logic preambleSeenEvent;
    logic syncMatchEvent;
    logic signalStrengthEvent;
    logic checkGoodEvent;
    logic payloadCompleteEvent;
  } rxs_events_type;

endpackage

// ---- hw/rxs_irq.sv ----
// Purpose: sticky event status, mask gating and one level interrupt
// Assumes: events are one-cycle pulses on clk
// Notes: a new event wins over a read-clear in the same cycle
`timescale 1ns/1ns
module rxs_irq import rxs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // events and control
  input wire logic [IRQ_W-1:0] eventPulse,
  input wire logic [IRQ_W-1:0] irqMask,
  input wire logic statusClear,
  // results
  output logic [IRQ_W-1:0] irqStatus,
  output logic irq
);

  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] status_nxt;
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    status_nxt = status_r;
    if (statusClear) begin
      status_nxt = '0;
    end
    status_nxt = status_nxt | eventPulse;
    irq_nxt = |(status_nxt & irqMask);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irqStatus = status_r;
  assign irq = irq_r;

endmodule // rxs_irq

// ---- hw/rxs_regs.sv ----
// Purpose: Avalon-MM slave with the transitions, control and mask registers
// Assumes: one wait cycle per access, data in byte lane 0
// Notes: unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ns
module rxs_regs import rxs_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon slave
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // block side
  input wire rxs_state_type seqState,
  input wire logic [IRQ_W-1:0] irqStatus,
  output rxs_trans_type trans,
  output logic lowEnergyChoice,
  output logic idleDepthBit,
  output logic [IRQ_W-1:0] irqMask,
  output logic cmdStart,
  output logic cmdStop,
  output logic statusClear,
  output logic codeWarn
);

  initial begin
    if (ADDR_W < 8) begin
      $error("rxs_regs needs at least 8 address bits");
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  logic ack_r, ack_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  rxs_trans_type trans_r, trans_nxt;
  logic lowE_r, lowE_nxt, depth_r, depth_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt;
  logic start_r, start_nxt, stop_r, stop_nxt;
  logic clr_nxt, warn_r, warn_nxt;
  logic doWrite;

  always_comb begin
    ack_nxt = (avsRead | avsWrite) & ~ack_r;
    wait_nxt = ~ack_nxt;
    rdata_nxt = rdata_r;
    trans_nxt = trans_r;
    lowE_nxt = lowE_r;
    depth_nxt = depth_r;
    mask_nxt = mask_r;
    start_nxt = 1'b0;
    stop_nxt = 1'b0;
    warn_nxt = 1'b0;
    clr_nxt = avsRead & ack_r & hit(avsAddress, IDX_IRQ);
    doWrite = avsWrite & ack_r & avsByteenable[0];
    if (ack_nxt && avsRead) begin
      rdata_nxt = 32'h0;
      if (hit(avsAddress, IDX_TRANS)) begin
        rdata_nxt[7:0] = trans_r;
      end else if (hit(avsAddress, IDX_CTRL)) begin
        rdata_nxt[CTRL_LOW_ENERGY] = lowE_r;
        rdata_nxt[CTRL_IDLE_DEPTH] = depth_r;
      end else if (hit(avsAddress, IDX_STATUS)) begin
        rdata_nxt[2:0] = seqState;
      end else if (hit(avsAddress, IDX_IRQ)) begin
        rdata_nxt[IRQ_W-1:0] = irqStatus;
      end else if (hit(avsAddress, IDX_MASK)) begin
        rdata_nxt[IRQ_W-1:0] = mask_r;
      end
    end
    if (doWrite) begin
      if (hit(avsAddress, IDX_TRANS)) begin
        trans_nxt = avsWritedata[7:0];
        warn_nxt = (avsWritedata[7:5] == RX_HALT_PREAMBLE) ||
                   (avsWritedata[7:5] == RX_UNUSED_LO) || (avsWritedata[7:5] == RX_UNUSED_HI);
      end else if (hit(avsAddress, IDX_CTRL)) begin
        lowE_nxt = avsWritedata[CTRL_LOW_ENERGY];
        depth_nxt = avsWritedata[CTRL_IDLE_DEPTH];
        start_nxt = avsWritedata[CTRL_START];
        stop_nxt = avsWritedata[CTRL_STOP];
      end else if (hit(avsAddress, IDX_MASK)) begin
        mask_nxt = avsWritedata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
      trans_r <= RST_TRANS;
      lowE_r <= RST_LOW_ENERGY;
      depth_r <= RST_IDLE_DEPTH;
      mask_r <= '0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      warn_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      trans_r <= trans_nxt;
      lowE_r <= lowE_nxt;
      depth_r <= depth_nxt;
      mask_r <= mask_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      warn_r <= warn_nxt;
    end
  end

  assign avsReaddata = rdata_r;
  assign avsWaitrequest = wait_r;
  assign trans = trans_r;
  assign lowEnergyChoice = lowE_r;
  assign idleDepthBit = depth_r;
  assign irqMask = mask_r;
  assign cmdStart = start_r;
  assign cmdStop = stop_r;
  assign statusClear = clr_nxt;
  assign codeWarn = warn_r;

endmodule // rxs_regs

// ---- dv/rxs_evt_model.sv ----
// Purpose: receive-path event source
// Assumes: idx 15 means no event
// Notes: each request gives one pulse
`timescale 1ns/1ns
module rxs_evt_model import rxs_pkg::*; (
  // clock
  input wire logic clk,
  // request
  input wire logic go,
  input wire logic [3:0] idx,
  // events
  output rxs_events_type ev
);
  // ------------------------------------------------------------
  // one-cycle pulse per request
  // ------------------------------------------------------------
  // expiry inputs apart
  always_ff @(posedge clk) begin
    ev <= go ? rxs_events_type'(9'h1 << idx) : '0;
  end
endmodule // rxs_evt_model

// ---- dv/tb.sv ----
// Purpose: transition table test of rxs_sequencer
// Assumes: one wait cycle per bus access
// Notes: case = trans, ctl, event, state, event, state; ctl bit3 marks no retune
`timescale 1ns/1ns
module tb import rxs_pkg::*; ;
  localparam logic [7:0] A_TR = IDX_TRANS << WORD_SHIFT;
  localparam logic [7:0] A_CT = IDX_CTRL << WORD_SHIFT;
  localparam logic [7:0] A_IR = IDX_IRQ << WORD_SHIFT;
  localparam logic [7:0] A_MK = IDX_MASK << WORD_SHIFT;
  localparam logic [27:0] TBL [20] = '{28'h24003f1, 28'h45000f0, 28'h45106f6, 28'h65013f3,
    28'h85020f0, 28'ha5030f0, 28'hc5040f0, 28'h25065f1, 28'h2d077f7, 28'h35386f6,
    28'h3d060f0, 28'h6d007f7, 28'h20003f0, 28'h22203f0, 28'h2100357, 28'h23003f2,
    28'h23803f1, 28'h8d067f7, 28'h7d000f0, 28'hdd070f0};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic go = 1'b0;
  logic freqChanged = 1'b1;
  logic [3:0] idx = 4'hf;
  logic [7:0] avsAddress = 8'h00;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata, rdat;
  logic [27:0] t;
  logic avsWaitrequest, receiverRelaunch, synthOnlyMode, initialMode, idleStandby, idleSleep, irq;
  rxs_events_type rxEvents;
  rxs_state_type seqState;
  int error_cnt = 0;
  int checks = 0;

  rxs_evt_model evm (.clk, .go, .idx, .ev(rxEvents));
  rxs_sequencer #(.ADDR_W(8)) dut (.clk, .sys_rst, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest, .rxEvents,
    .freqChanged, .seqState, .receiverRelaunch, .synthOnlyMode, .initialMode,
    .idleStandby, .idleSleep, .irq);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= !w;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0) @(posedge clk);
    rdat = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fire(input logic [3:0] i, input logic [2:0] s);
    @(posedge clk);
    if (i != 4'hf) begin
      go <= 1'b1;
      idx <= i;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
    end
    #1;
    chk(seqState, s);
  endtask
  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, A_TR, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0);
    foreach (TBL[n]) begin
      t = TBL[n];
      bus(1'b1, A_CT, 32'h8);
      freqChanged <= !t[19];
      bus(1'b1, A_TR, {24'h0, t[27:20]});
      bus(1'b1, A_CT, {29'h0, 1'b1, t[17:16]});
      fire(4'hf, 3'h1);
      fire(t[15:12], t[10:8]);
      chk(receiverRelaunch, t[10:8] == 3'h5);
      fire(t[7:4], t[2:0]);
      chk(synthOnlyMode, t[2:0] == 3'h2);
      chk(initialMode, t[3:0] == 4'h0);
      chk({idleSleep, idleStandby}, t[3:0] != 4'h6 ? 2'h0 : (t[17] ? 2'h2 : 2'h1));
      $display("case %0d done", n);
    end
    bus(1'b1, A_MK, 32'h1);
    #1;
    chk(irq, 1'b1);
    bus(1'b0, A_IR, 32'h0);
    #1;
    chk(rdat, 32'h1f);
    chk(irq, 1'b0);
    $display("irq test done");
    print_verdict();
  end
endmodule // tb
